//--- pkg/spi_eeprom_defs.vh
// Constants for the serial EEPROM command decoder and protection logic.
`ifndef SPI_EEPROM_DEFS_VH
`define SPI_EEPROM_DEFS_VH

`define EE_OP_MASK 8'hf7
`define EE_OP_SET_LATCH 8'h06
`define EE_OP_CLR_LATCH 8'h04
`define EE_OP_RD_STATUS 8'h05
`define EE_OP_WR_STATUS 8'h01
`define EE_OP_RD_ARRAY 8'h03
`define EE_OP_WR_ARRAY 8'h02
`define EE_OP_NONE 8'h00

`define EE_ST_BUSY 0
`define EE_ST_LATCH 1
`define EE_ST_BP_LO 2
`define EE_ST_BP_HI 3
`define EE_ST_PROT_EN 7
`define EE_STATUS_BUSY_VAL 8'hff

`define EE_BP_NONE 2'b00
`define EE_BP_QUARTER 2'b01
`define EE_BP_HALF 2'b10
`define EE_BP_ALL 2'b11

`define EE_ADDR_W 12
`define EE_PAGE_W 5
`define EE_PAGE_BYTES 32

`define EE_TWC_MS 5
`define EE_CLK_HZ 40000000
`define EE_WR_CYCLES ((`EE_TWC_MS * `EE_CLK_HZ) / 1000)

`endif

//--- hdl/pin_sync.v
// Two-flop synchronisers for the serial link pins.
module pin_sync #(
  parameter WIDTH = 4
) (
  // Clock, reset and enable.
  input wire clk_in,
  input wire srst_in,
  input wire ce_in,
  // Asynchronous pins and their synchronised copies.
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Each bit owns its flops, so no vector is driven from several processes.
      reg meta_r;
      reg sync_r;
      always @(posedge clk_in) begin
        if (srst_in) begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end else if (ce_in) begin
          meta_r <= pin_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate
endmodule // pin_sync

//--- hdl/eeprom_array.v
// Byte-wide storage for the memory array, one write and one read port.
module eeprom_array #(
  parameter ADDR_W = 12,
  parameter DATA_W = 8
) (
  // Clock and enable.
  input wire clk_in,
  input wire ce_in,
  // Write port.
  input wire wr_en_in,
  input wire [ADDR_W-1:0] wr_addr_in,
  input wire [DATA_W-1:0] wr_data_in,
  // Read port, combinational.
  input wire [ADDR_W-1:0] rd_addr_in,
  output wire [DATA_W-1:0] rd_data_out
);
  // Contents survive the synchronous reset, as a non-volatile array should.
  reg [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];
  always @(posedge clk_in) begin
    if (ce_in && wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end
  assign rd_data_out = mem_r[rd_addr_in];
endmodule // eeprom_array

//--- hdl/spi_eeprom_command_protect.v
// Serial EEPROM slave: command decode, status register, protection and page write.
`include "spi_eeprom_defs.vh"
module spi_eeprom_command_protect #(
  parameter ADDR_W = `EE_ADDR_W,
  parameter PAGE_W = `EE_PAGE_W,
  parameter WR_CYCLES = `EE_WR_CYCLES
) (
  // Clock, reset and enable.
  input wire clk_in,
  input wire srst_in,
  input wire ce_in,
  // Serial link pins.
  input wire cs_n_in,
  input wire sck_in,
  input wire si_in,
  input wire wp_n_in,
  // Serial output and its enable, enable low while driving.
  output reg so_out,
  output reg so_oe_n_out,
  // Internal write cycle in progress.
  output reg busy_out
);
  localparam [2:0] ST_OPC = 3'd0;
  localparam [2:0] ST_ADDR_HI = 3'd1;
  localparam [2:0] ST_ADDR_LO = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_SDATA = 3'd4;
  localparam [2:0] ST_RDOUT = 3'd5;
  localparam [2:0] ST_STOUT = 3'd6;
  localparam [2:0] ST_SKIP = 3'd7;
  localparam PAGE_N = 1 << PAGE_W;
  // The write time must be at least the page size, or the commit walk is cut short.
  localparam integer WR_LAST_I = WR_CYCLES - 1;
  localparam [23:0] WR_LAST = WR_LAST_I[23:0];

  // Protected region lookup for one array address.
  function prot_hit;
    input [ADDR_W-1:0] a;
    input [1:0] bp;
    begin
      case (bp)
        `EE_BP_NONE: prot_hit = 1'b0;
        `EE_BP_QUARTER: prot_hit = (a[ADDR_W-1:ADDR_W-2] == 2'b11);
        `EE_BP_HALF: prot_hit = a[ADDR_W-1];
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  wire [3:0] pins_s;
  wire cs_s = pins_s[3];
  wire sck_s = pins_s[2];
  wire si_s = pins_s[1];
  wire wp_n_s = pins_s[0];

  pin_sync #(.WIDTH(4)) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .pin_in({cs_n_in, sck_in, si_in, wp_n_in}),
    .sync_out(pins_s)
  );

  reg sck_d_r;
  reg cs_d_r;
  reg [2:0] st_r;
  reg [2:0] bit_cnt_r;
  reg [6:0] sh_r;
  reg [7:0] op_r;
  reg [7:0] out_sr_r;
  reg load_pend_r;
  reg [ADDR_W-1:0] addr_r;
  reg got_data_r;
  reg got_sdata_r;
  reg [7:0] sdata_r;
  reg wel_r;
  reg [1:0] bp_r;
  reg prot_en_r;
  reg [1:0] bp_new_r;
  reg prot_en_new_r;
  reg wr_stat_r;
  reg [23:0] tmr_r;
  reg [7:0] page_buf_r [0:PAGE_N-1];
  reg [PAGE_N-1:0] page_mask_r;

  wire sck_rise = ~cs_s & sck_s & ~sck_d_r;
  wire sck_fall = ~cs_s & ~sck_s & sck_d_r;
  wire cs_rise = cs_s & ~cs_d_r;
  wire [7:0] byte_nxt = {sh_r, si_s};
  wire byte_done = sck_rise && (bit_cnt_r == 3'd7);
  wire hw_prot = prot_en_r & ~wp_n_s;
  wire [7:0] op_dec = byte_nxt & `EE_OP_MASK;

  // Status as read: all ones while busy, unused bits read zero otherwise.
  wire [7:0] status_val = busy_out ? `EE_STATUS_BUSY_VAL :
    {prot_en_r, 3'b000, bp_r, wel_r, 1'b0};

  // Array commit walks the page buffer during the first cycles of the write timer.
  wire [PAGE_W-1:0] cm_idx = tmr_r[PAGE_W-1:0];
  wire [ADDR_W-1:0] cm_addr = {addr_r[ADDR_W-1:PAGE_W], cm_idx};
  wire cm_we = busy_out && !wr_stat_r && (tmr_r < PAGE_N) &&
    page_mask_r[cm_idx] && !prot_hit(cm_addr, bp_r);
  wire [7:0] rd_data;

  eeprom_array #(.ADDR_W(ADDR_W), .DATA_W(8)) u_array (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .wr_en_in(cm_we),
    .wr_addr_in(cm_addr),
    .wr_data_in(page_buf_r[cm_idx]),
    .rd_addr_in(addr_r),
    .rd_data_out(rd_data)
  );

  // Page buffer; the mask marks bytes that will be committed.
  always @(posedge clk_in) begin
    if (srst_in) begin
      page_mask_r <= {PAGE_N{1'b0}};
    end else if (ce_in) begin
      if (st_r == ST_ADDR_LO && byte_done) begin
        page_mask_r <= {PAGE_N{1'b0}};
      end else if (st_r == ST_WDATA && byte_done && !cs_s) begin
        page_buf_r[addr_r[PAGE_W-1:0]] <= byte_nxt;
        page_mask_r[addr_r[PAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  // Write-cycle timer and non-volatile status update.
  always @(posedge clk_in) begin
    if (srst_in) begin
      busy_out <= 1'b0;
      tmr_r <= 24'h000000;
      wel_r <= 1'b0;
      bp_r <= 2'b00;
      prot_en_r <= 1'b0;
      bp_new_r <= 2'b00;
      prot_en_new_r <= 1'b0;
      wr_stat_r <= 1'b0;
    end else if (ce_in) begin
      if (busy_out) begin
        if (tmr_r == WR_LAST) begin
          busy_out <= 1'b0;
          tmr_r <= 24'h000000;
          wel_r <= 1'b0;
          if (wr_stat_r) begin
            bp_r <= bp_new_r;
            prot_en_r <= prot_en_new_r;
          end
        end else begin
          tmr_r <= tmr_r + 24'h000001;
        end
      end else if (cs_rise && bit_cnt_r == 3'd0) begin
        case (op_r)
          `EE_OP_SET_LATCH: begin
            wel_r <= 1'b1;
          end
          `EE_OP_CLR_LATCH: begin
            wel_r <= 1'b0;
          end
          `EE_OP_WR_STATUS: begin
            if (got_sdata_r && wel_r && !hw_prot) begin
              busy_out <= 1'b1;
              wr_stat_r <= 1'b1;
              bp_new_r <= {sdata_r[`EE_ST_BP_HI], sdata_r[`EE_ST_BP_LO]};
              // Protect enable may fall only with the pin already high.
              prot_en_new_r <= (prot_en_r & ~wp_n_s) | sdata_r[`EE_ST_PROT_EN];
            end else if (got_sdata_r) begin
              wel_r <= 1'b0;
            end
          end
          `EE_OP_WR_ARRAY: begin
            if (got_data_r && wel_r) begin
              busy_out <= 1'b1;
              wr_stat_r <= 1'b0;
            end
          end
          default: begin
            wel_r <= wel_r;
          end
        endcase
      end
    end
  end

  // Serial command engine.
  always @(posedge clk_in) begin
    if (srst_in) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      st_r <= ST_OPC;
      bit_cnt_r <= 3'd0;
      sh_r <= 7'h00;
      op_r <= `EE_OP_NONE;
      out_sr_r <= 8'h00;
      load_pend_r <= 1'b0;
      addr_r <= {ADDR_W{1'b0}};
      got_data_r <= 1'b0;
      got_sdata_r <= 1'b0;
      sdata_r <= 8'h00;
      so_out <= 1'b0;
      so_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_s;
      if (cs_s) begin
        // A frame ends here; a mid-byte end leaves bit_cnt nonzero and nothing launches.
        st_r <= ST_OPC;
        bit_cnt_r <= 3'd0;
        so_oe_n_out <= 1'b1;
        load_pend_r <= 1'b0;
        if (!cs_rise) begin
          op_r <= `EE_OP_NONE;
          got_data_r <= 1'b0;
          got_sdata_r <= 1'b0;
        end
      end else begin
        if (load_pend_r) begin
          load_pend_r <= 1'b0;
          out_sr_r <= rd_data;
          addr_r <= addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
        if (sck_rise) begin
          sh_r <= byte_nxt[6:0];
          bit_cnt_r <= bit_cnt_r + 3'd1;
        end
        if (sck_fall && (st_r == ST_RDOUT || st_r == ST_STOUT)) begin
          so_out <= out_sr_r[7];
          out_sr_r <= {out_sr_r[6:0], 1'b0};
          so_oe_n_out <= 1'b0;
        end
        if (byte_done) begin
          case (st_r)
            ST_OPC: begin
              if (busy_out && op_dec != `EE_OP_RD_STATUS) begin
                op_r <= `EE_OP_NONE;
                st_r <= ST_SKIP;
              end else begin
                op_r <= op_dec;
                case (op_dec)
                  `EE_OP_RD_STATUS: begin
                    st_r <= ST_STOUT;
                    out_sr_r <= status_val;
                  end
                  `EE_OP_RD_ARRAY: st_r <= ST_ADDR_HI;
                  `EE_OP_WR_ARRAY: st_r <= ST_ADDR_HI;
                  `EE_OP_WR_STATUS: st_r <= ST_SDATA;
                  `EE_OP_SET_LATCH: st_r <= ST_SKIP;
                  `EE_OP_CLR_LATCH: st_r <= ST_SKIP;
                  default: begin
                    op_r <= `EE_OP_NONE;
                    st_r <= ST_SKIP;
                  end
                endcase
              end
            end
            ST_ADDR_HI: begin
              addr_r[ADDR_W-1:8] <= byte_nxt[ADDR_W-9:0];
              st_r <= ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
              addr_r[7:0] <= byte_nxt;
              if (op_r == `EE_OP_RD_ARRAY) begin
                st_r <= ST_RDOUT;
                load_pend_r <= 1'b1;
              end else begin
                st_r <= ST_WDATA;
              end
            end
            ST_WDATA: begin
              got_data_r <= 1'b1;
              // Only the low page bits advance, so the page start follows its end.
              addr_r[PAGE_W-1:0] <= addr_r[PAGE_W-1:0] + {{(PAGE_W-1){1'b0}}, 1'b1};
            end
            ST_SDATA: begin
              sdata_r <= byte_nxt;
              got_sdata_r <= 1'b1;
              st_r <= ST_SKIP;
            end
            ST_RDOUT: begin
              load_pend_r <= 1'b1;
            end
            ST_STOUT: begin
              out_sr_r <= status_val;
            end
            default: begin
              st_r <= ST_SKIP;
            end
          endcase
        end else if (sck_rise && st_r == ST_SKIP && bit_cnt_r == 3'd0 &&
                     op_r != `EE_OP_WR_STATUS) begin
          // Extra clocking after a complete short command cancels it.
          op_r <= `EE_OP_NONE;
        end
      end
    end
  end
endmodule // spi_eeprom_command_protect

//--- verif/spi_eeprom_command_protect_asserts.sv
// Port-level assertions for the serial EEPROM command and protection block.
module spi_eeprom_command_protect_asserts #(
  parameter int WR_CYCLES = 400
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  input wire logic so_out,
  input wire logic so_oe_n_out,
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cs_h;
  logic [4:0] sck_h;
  logic [2:0] bits_r;
  logic whole_r;
  logic [31:0] bcnt_r;
  logic sck_fell;
  // Histories lag the pins so that the synchroniser delay of the design fits inside them.
  assign sck_fell = |(sck_h[4:1] & ~sck_h[3:0]);
  always @(posedge clk_in) begin
    if (srst_in) begin
      cs_h <= 5'h1f;
      sck_h <= 5'h00;
      bits_r <= 3'h0;
      whole_r <= 1'b1;
      bcnt_r <= 32'h0;
    end else if (ce_in) begin
      cs_h <= {cs_h[3:0], cs_n_in};
      sck_h <= {sck_h[3:0], sck_in};
      bcnt_r <= busy_out ? bcnt_r + 32'h1 : 32'h0;
      if (cs_n_in) begin
        bits_r <= 3'h0;
        if (!cs_h[0]) begin
          whole_r <= (bits_r == 3'h0);
        end
      end else if (sck_in && !sck_h[0]) begin
        bits_r <= bits_r + 3'h1;
      end
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence cs_idle_s;
    cs_n_in [*6];
  endsequence
  sequence busy_run_s;
    busy_out [*8];
  endsequence
  AST_RESET_IDLE: assert property (disable iff (1'b0) srst_in && ce_in |=> so_oe_n_out && !busy_out)
    else $error("outputs not idle after reset");
  AST_CS_IDLE_HIZ: assert property (cs_idle_s |-> so_oe_n_out)
    else $error("output driven while deselected");
  AST_OE_NEEDS_CS: assert property (!so_oe_n_out |-> cs_h != 5'h1f)
    else $error("output enabled without select");
  AST_OE_ON_FALL: assert property ($fell(so_oe_n_out) |-> sck_fell)
    else $error("output enabled off a falling clock");
  AST_SO_ON_FALL: assert property (!so_oe_n_out && $past(!so_oe_n_out) && cs_h == 5'h00 &&
    $changed(so_out) |-> sck_fell)
    else $error("output changed off a falling clock");
  AST_BUSY_LAUNCH: assert property ($rose(busy_out) |-> cs_n_in && whole_r)
    else $error("write cycle launched by a bad frame");
  AST_BUSY_HOLDS: assert property ($rose(busy_out) |=> busy_run_s)
    else $error("write cycle ended early");
  AST_BUSY_LENGTH: assert property ($fell(busy_out) |-> bcnt_r >= WR_CYCLES - 1 &&
    bcnt_r <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
endmodule // spi_eeprom_command_protect_asserts

bind spi_eeprom_command_protect spi_eeprom_command_protect_asserts #(
  .WR_CYCLES(WR_CYCLES)
) i_spi_eeprom_command_protect_asserts (
  .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
  .si_in(si_in), .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_n_out(so_oe_n_out),
  .busy_out(busy_out)
);

//--- verif/spi_master_model.sv
// Mode 0 serial master model that drives the link pins of the EEPROM block.
module spi_master_model (
  // Clock.
  input wire logic clk_in,
  // Link towards the device.
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_n_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_b;
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    last_b = 1'b0;
  end
  // Half a link period is four system clocks, the least the device samples reliably.
  task automatic half();
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task automatic sel();
    cs_n_out = 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_out = tx[i];
      half();
      // A released line shows the inverse of the last bit, never a lucky match.
      rx[i] = so_oe_n_in ? ~last_b : so_in;
      last_b = rx[i];
      sck_out = 1'b1;
      half();
      sck_out = 1'b0;
    end
  endtask
  // A few bare clocks, used to end a frame away from a byte boundary.
  task automatic part(input int n);
    for (int i = 0; i < n; i++) begin
      half();
      sck_out = 1'b1;
      half();
      sck_out = 1'b0;
    end
  endtask
  task automatic desel();
    half();
    cs_n_out = 1'b1;
    half();
    half();
  endtask
endmodule // spi_master_model

//--- verif/spi_eeprom_command_protect_tb_top.sv
// Self-checking testbench for the serial EEPROM command and protection block.
module spi_eeprom_command_protect_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in;
  logic srst_in;
  logic ce_in;
  logic wp_n_in;
  logic [7:0] r0;
  logic [7:0] r1;
  wire cs_n, sck, si, so, so_oe_n, busy;
  int fail_count;
  int checks_done;
  spi_eeprom_command_protect #(.WR_CYCLES(400)) i_spi_eeprom_command_protect (
    .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .wp_n_in(wp_n_in), .so_out(so), .so_oe_n_out(so_oe_n), .busy_out(busy));
  spi_master_model i_spi_master_model (
    .clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .so_in(so),
    .so_oe_n_in(so_oe_n));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic sb(input logic [7:0] b);
    r1 = r0;
    i_spi_master_model.xfer(b, r0);
  endtask
  task automatic op(input logic [7:0] b);
    i_spi_master_model.sel();
    sb(b);
    i_spi_master_model.desel();
  endtask
  task automatic rd_st();
    i_spi_master_model.sel();
    sb(8'h05);
    sb(8'h00);
    i_spi_master_model.desel();
  endtask
  task automatic wr_st(input logic [7:0] d);
    i_spi_master_model.sel();
    sb(8'h01);
    sb(d);
    i_spi_master_model.desel();
  endtask
  task automatic wr_a(input logic [15:0] a, input logic [7:0] d0, d1, input logic two);
    i_spi_master_model.sel();
    sb(8'h02);
    sb(a[15:8]);
    sb(a[7:0]);
    sb(d0);
    if (two) begin
      sb(d1);
    end
    i_spi_master_model.desel();
  endtask
  task automatic rd_a(input logic [15:0] a);
    i_spi_master_model.sel();
    sb(8'h03);
    sb(a[15:8]);
    sb(a[7:0]);
    sb(8'h00);
    sb(8'h00);
    i_spi_master_model.desel();
  endtask
  task automatic idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 600) begin
      @(posedge clk_in);
      k++;
    end
    if (k >= 600) begin
      fail_count++;
      $display("CHECK FAILED %0t: write cycle hung", $time);
    end
  endtask
  task automatic wa(input logic [15:0] a, input logic [7:0] d);
    op(8'h06);
    wr_a(a, d, 8'h00, 1'b0);
    idle();
  endtask
  task automatic ws(input logic [7:0] d);
    op(8'h06);
    wr_st(d);
    idle();
  endtask
  task automatic t_latch();
    logic [7:0] c [4];
    c = '{8'h06, 8'h04, 8'h0e, 8'h0c};
    rd_st();
    check(r0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      op(c[i]);
      rd_st();
      check(r0, {6'h00, c[i][1], 1'b0});
    end
    $display("test latch done");
  endtask
  task automatic t_status();
    op(8'h06);
    wr_st(8'hfc);
    rd_st();
    check(r0, 8'hff);
    idle();
    rd_st();
    check(r0, 8'h8c);
    wp_n_in = 1'b0;
    op(8'h06);
    rd_st();
    check(r0, 8'h8e);
    wr_st(8'h00);
    idle();
    rd_st();
    check(r0, 8'h8c);
    wp_n_in = 1'b1;
    ws(8'h00);
    rd_st();
    check(r0, 8'h00);
    $display("test status done");
  endtask
  task automatic t_array();
    op(8'h06);
    wr_a(16'h0000, 8'h11, 8'h00, 1'b0);
    // A low clock enable must freeze the write timer past its normal end.
    ce_in = 1'b0;
    repeat (450) @(posedge clk_in);
    check({7'h00, busy}, 8'h01);
    #1;
    ce_in = 1'b1;
    idle();
    op(8'h06);
    wr_a(16'hffff, 8'ha5, 8'h5a, 1'b1);
    op(8'h06);
    idle();
    rd_st();
    check(r0, 8'h00);
    rd_a(16'h0fff);
    check(r1, 8'ha5);
    check(r0, 8'h11);
    rd_a(16'h5fe0);
    check(r1, 8'h5a);
    $display("test array done");
  endtask
  task automatic t_prot();
    wa(16'h0800, 8'h33);
    ws(8'h88);
    wp_n_in = 1'b0;
    wa(16'h0800, 8'h77);
    wa(16'h0000, 8'h22);
    wr_a(16'h0000, 8'h99, 8'h00, 1'b0);
    idle();
    rd_a(16'h0800);
    check(r1, 8'h33);
    rd_a(16'h0000);
    check(r1, 8'h22);
    wp_n_in = 1'b1;
    ws(8'h04);
    wa(16'h0800, 8'h55);
    rd_a(16'h0800);
    check(r1, 8'h55);
    wa(16'h0fff, 8'h66);
    rd_a(16'h0fff);
    check(r1, 8'ha5);
    op(8'h06);
    i_spi_master_model.sel();
    sb(8'h02);
    sb(8'h00);
    sb(8'h10);
    sb(8'hee);
    i_spi_master_model.part(3);
    i_spi_master_model.desel();
    check({7'h00, busy}, 8'h00);
    rd_st();
    check(r0, 8'h06);
    $display("test protect done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // The run needs well under a millisecond; the margin absorbs slower write cycles.
  initial begin
    #2000000;
    fail_count++;
    conclude();
  end
  initial begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    wp_n_in = 1'b1;
    r0 = 8'h00;
    r1 = 8'h00;
    fail_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    t_latch();
    t_status();
    t_array();
    t_prot();
    conclude();
  end
endmodule // spi_eeprom_command_protect_tb_top
